// ==== hw/dbmi_lane_codec.sv ====
/*
 * Mask / bus-inversion codec for both byte lanes of one DRAM channel.
 * Mode register levels arrive on the core clock and are synchronised
 * into the link clock domain, where every beat is decoded. Illegal
 * masked writes are reported back to the core as a pulse.
 * Assumes the controller delivers one beat per link clock edge with
 * beat_valid_in, and that mode bits change only while the link idles.
 */
`timescale 1ns/1ps

module dbmi_lane_codec
    import dbmi_pkg::*;
#(
    parameter int FIFO_DEPTH = WR_FIFO_DEPTH
) (
    // Core clock domain
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_b_in,
    input  wire logic [MODE_REG_W-1:0] mode_reg_three_in,
    input  wire logic [MODE_REG_W-1:0] mode_reg_thirteen_in,
    input  wire logic                  burst_long_in,
    output logic                       illegal_mw_out,
    // Link clock domain: command and beats
    input  wire logic                  link_clk_in,
    input  wire logic                  cmd_valid_in,
    input  wire dbmi_cmd_t             cmd_in,
    input  wire logic                  beat_valid_in,
    input  wire dbmi_beat_t            beat_in,
    // Link clock domain: array write and pin drive
    output dbmi_wr_t                   wr_out,
    output dbmi_rd_t                   rd_out,
    output logic                       burst_busy_out
);

    localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

    // ****************************************************************
    // Mode enables, core domain
    // ****************************************************************
    dbmi_cfg_t cfg_core_w;

    assign cfg_core_w.wr_inv     = mode_reg_three_in[MR3_WR_INV_BIT];   // [RL3]
    assign cfg_core_w.rd_inv     = mode_reg_three_in[MR3_RD_INV_BIT];   // [RL4]
    assign cfg_core_w.mask       = mode_reg_thirteen_in[MODE_REG_THIRTEEN_MASK_BIT]; // [RL5]
    assign cfg_core_w.burst_long = burst_long_in;

    dbmi_cfg_t cfg_core_reg;

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            cfg_core_reg <= '0;
        end else begin
            cfg_core_reg <= cfg_core_w;
        end
    end

    // ****************************************************************
    // Reset and enables into the link domain
    // ****************************************************************
    // The link reset is a synchronised copy of the core reset, so the
    // core reset must span at least three link clock edges.
    logic      link_rst_s1_reg;
    logic      link_rst_b_reg;
    dbmi_cfg_t cfg_s1_reg;
    dbmi_cfg_t cfg_reg;

    always_ff @(posedge link_clk_in) begin
        link_rst_s1_reg <= rst_b_in;
        link_rst_b_reg  <= link_rst_s1_reg;
    end

    // Enables are quasi-static levels, so a plain two-flop crossing is safe
    always_ff @(posedge link_clk_in) begin
        if (!link_rst_b_reg) begin
            cfg_s1_reg <= '0;
            cfg_reg    <= '0;
        end else begin
            cfg_s1_reg <= cfg_core_reg;
            cfg_reg    <= cfg_s1_reg;
        end
    end

    // ****************************************************************
    // Burst sequencer
    // ****************************************************************
    dbmi_state_t             state_reg;
    dbmi_state_t             state_next;
    dbmi_cmd_t               cmd_reg;
    logic [BEAT_CNT_W-1:0]   beat_cnt_reg;
    logic [BEAT_CNT_W-1:0]   beat_cnt_next;
    logic [BEAT_CNT_W-1:0]   burst_len_reg;
    logic [BEAT_CNT_W-1:0]   burst_len_w;

    wire logic start_w = (state_reg == ST_IDLE) && cmd_valid_in;
    wire logic beat_w  = (state_reg == ST_BURST) && beat_valid_in;
    wire logic last_w  = beat_w && (beat_cnt_reg == burst_len_reg - 6'h01);

    // Masked writes never run past sixteen beats, even in long mode
    assign burst_len_w = (cmd_in == CMD_MASKED_WRITE) ? MASKED_BURST_LEN :   // [RL20]
                         cfg_reg.burst_long ? BURST_LEN_LONG : BURST_LEN_SHORT;

    always_comb begin
        state_next    = state_reg;
        beat_cnt_next = beat_cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                beat_cnt_next = '0;
                if (cmd_valid_in) begin
                    state_next = ST_BURST;
                end
            end
            ST_BURST: begin
                if (last_w) begin
                    state_next    = ST_IDLE;
                    beat_cnt_next = '0;
                end else if (beat_valid_in) begin
                    beat_cnt_next = beat_cnt_reg + 6'h01;
                end
            end
            default: begin
                state_next    = ST_IDLE;
                beat_cnt_next = '0;
            end
        endcase
    end

    always_ff @(posedge link_clk_in) begin
        if (!link_rst_b_reg) begin
            state_reg     <= ST_IDLE;
            beat_cnt_reg  <= '0;
            cmd_reg       <= CMD_WRITE;
            burst_len_reg <= BURST_LEN_SHORT;
        end else begin
            state_reg    <= state_next;
            beat_cnt_reg <= beat_cnt_next;
            if (start_w) begin
                cmd_reg       <= cmd_in;
                burst_len_reg <= burst_len_w;
            end
        end
    end

    assign burst_busy_out = (state_reg == ST_BURST);

    // ****************************************************************
    // Command decode for the current beat
    // ****************************************************************
    wire logic any_en_w = cfg_reg.wr_inv | cfg_reg.rd_inv | cfg_reg.mask;
    wire logic rx_on_w  = cfg_reg.wr_inv | cfg_reg.mask;
    wire logic is_wr_w  = beat_w && (cmd_reg == CMD_WRITE);
    wire logic is_mw_w  = beat_w && (cmd_reg == CMD_MASKED_WRITE);
    wire logic is_rd_w  = beat_w && (cmd_reg == CMD_READ);
    wire logic is_mrr_w = beat_w && (cmd_reg == CMD_MODE_REG_READ);
    wire logic is_wf_w  = beat_w && (cmd_reg == CMD_WRITE_FIFO_TRAINING);
    wire logic is_rf_w  = beat_w && (cmd_reg == CMD_READ_FIFO_TRAINING);
    wire logic is_cal_w = beat_w && (cmd_reg == CMD_READ_DQ_CAL);

    // Masked write with masking off is refused and reported, not written
    wire logic mw_ok_w      = is_mw_w && cfg_reg.mask;                     // [RL10]
    wire logic illegal_mw_w = is_mw_w && !cfg_reg.mask && (beat_cnt_reg == '0);

    // Receivers off when neither write inversion nor masking is on
    wire logic [LANES-1:0] pin_rx_w = rx_on_w ? beat_in.pin : '0;          // [RL8]

    // ****************************************************************
    // Write-FIFO training pattern store
    // ****************************************************************
    logic [LANES-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] fifo_wptr_reg;
    logic [PTR_W-1:0] fifo_rptr_reg;

    wire logic [LANES-1:0] fifo_rd_w = fifo_mem[fifo_rptr_reg];

    // Pattern storage is not reset; it holds what the last write-FIFO left
    always_ff @(posedge link_clk_in) begin
        if (is_wf_w) begin
            fifo_mem[fifo_wptr_reg] <= any_en_w ? beat_in.pin : '0;        // [RL16]
        end
    end

    always_ff @(posedge link_clk_in) begin
        if (!link_rst_b_reg) begin
            fifo_wptr_reg <= '0;
            fifo_rptr_reg <= '0;
        end else begin
            if (start_w) begin
                fifo_wptr_reg <= '0;
                fifo_rptr_reg <= '0;
            end else begin
                if (is_wf_w) begin
                    fifo_wptr_reg <= fifo_wptr_reg + PTR_W'(1);
                end
                if (is_rf_w) begin
                    fifo_rptr_reg <= fifo_rptr_reg + PTR_W'(1);
                end
            end
        end
    end

    // ****************************************************************
    // Per-lane codec
    // ****************************************************************
    function automatic logic [3:0] count_ones(input logic [LANE_W-1:0] d,
                                             input int lo);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < LANE_W; i++) begin
            if (i >= lo) begin
                n = n + {3'h0, d[i]};
            end
        end
        return n;
    endfunction

    dbmi_wr_t wr_next;
    dbmi_rd_t rd_next;

    assign wr_next.valid = is_wr_w | mw_ok_w | is_wf_w;

    for (genvar g = 0; g < LANES; g++) begin : g_lane                      // [RL2] [RL6]
        wire logic [LANE_W-1:0] dq_b  = beat_in.dq[g];                      // [RL7]
        wire logic              pin_b = pin_rx_w[g];                        // [RL7]
        wire logic [LANE_W-1:0] rd_b  = beat_in.rd_data[g];
        wire logic [3:0] up_ones      = count_ones(dq_b, MASK_SENSE_LO);
        wire logic [3:0] rd_ones      = count_ones(rd_b, 0);

        // Mask only: a high pin masks; both on: low pin plus five upper ones masks
        wire logic mw_mask = cfg_reg.wr_inv ?
                             (!pin_b && (up_ones >= MASK_ONES_GE)) :       // [RL15]
                             pin_b;                                         // [RL14]

        // Regular write never masks; with inversion off the pin is unused
        wire logic wr_flip = cfg_reg.wr_inv && pin_b &&                     // [RL11] [RL13]
                             (is_wr_w || (mw_ok_w && !mw_mask));           // [RL15]

        // Decided on this beat's own eight bits only
        wire logic rd_flip = is_rd_w && cfg_reg.rd_inv &&                   // [RL12] [RL21]
                             (rd_ones > RD_INV_ONES_GT);

        // Write-FIFO data passes straight through, never masked or flipped
        assign wr_next.data[g]    = wr_flip ? ~dq_b : dq_b;                 // [RL16]
        assign wr_next.byte_en[g] = is_wr_w || is_wf_w ||
                                    (mw_ok_w && !mw_mask);                  // [RL14]

        // Read data is never masked, only optionally inverted
        assign rd_next.dq[g]    = rd_flip ? ~rd_b : rd_b;                   // [RL1]
        assign rd_next.dq_oe[g] = is_rd_w | is_mrr_w | is_rf_w | is_cal_w;

        // Mode register read drives a low pin; training drives the pattern
        assign rd_next.pin[g] = rd_flip ||                                  // [RL12]
                                (is_rf_w && any_en_w && fifo_rd_w[g]) ||    // [RL17]
                                (is_cal_w && any_en_w && beat_in.cal[g]);   // [RL19]
        assign rd_next.pin_oe[g] = ((is_rd_w || is_mrr_w) && cfg_reg.rd_inv) || // [RL9] [RL18]
                                   ((is_rf_w || is_cal_w) && any_en_w);     // [RL9]
    end

    // ****************************************************************
    // Registered outputs on the link side
    // ****************************************************************
    always_ff @(posedge link_clk_in) begin
        if (!link_rst_b_reg) begin
            wr_out <= '0;
            rd_out <= '0;
        end else begin
            wr_out <= wr_next;
            rd_out <= rd_next;
        end
    end

    // ****************************************************************
    // Illegal masked write event back to the core
    // ****************************************************************
    // A toggle crosses cleanly if the core samples it at least once between two illegal masked writes
    logic illegal_tgl_reg;
    logic ill_s1_reg;
    logic ill_s2_reg;
    logic ill_s3_reg;

    always_ff @(posedge link_clk_in) begin
        if (!link_rst_b_reg) begin
            illegal_tgl_reg <= 1'b0;
        end else if (illegal_mw_w) begin
            illegal_tgl_reg <= ~illegal_tgl_reg;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_b_in) begin
            ill_s1_reg     <= 1'b0;
            ill_s2_reg     <= 1'b0;
            ill_s3_reg     <= 1'b0;
            illegal_mw_out <= 1'b0;
        end else begin
            ill_s1_reg     <= illegal_tgl_reg;
            ill_s2_reg     <= ill_s1_reg;
            ill_s3_reg     <= ill_s2_reg;
            illegal_mw_out <= ill_s2_reg ^ ill_s3_reg;
        end
    end

endmodule

// ==== hw/dbmi_pkg.sv ====
/*
 * Constants, command and state types and carrier structs for the
 * per-byte-lane mask / bus-inversion block of a low-power DRAM.
 * Assumes two byte lanes per channel, one beat per link clock edge
 * and mode register bits delivered as plain levels from the core.
 */
//
// Behaviour
// RL1: Masking applies to write traffic only
// RL2: Mask and inversion decided per byte lane
// RL3: Mode reg three bit 7 enables write inversion
// RL4: Mode reg three bit 6 enables read inversion
// RL5: Mode reg thirteen bit 5 enables masking
// RL6: One mask/invert pin per lane, two lanes
// RL7: Pin sampled with its lane's DQ beats
// RL8: All write enables off: pin receivers off (code samples the pin in write-FIFO training with read inversion on)
// RL9: Read inversion off: pin drivers stay off (code drives them in FIFO training and calibration)
// RL10: Controller issues no masked write unmasked mode
// RL11: Write inversion: pin high inverts lane data
// RL12: Read: more than four ones inverts, pin high
// RL13: Mask only, regular write: no mask, pin low
// RL14: Mask only: pin high masks the beat
// RL15: Both on: pin low, five upper ones masks
// RL16: Write-FIFO training: pin is pattern, data untouched
// RL17: Read-FIFO training returns stored pin pattern
// RL18: Mode register read: no inversion, pin low
// RL19: DQ calibration: pin is training pattern
// RL20: Masked writes always carry sixteen beats
// RL21: Read inversion decided per beat per lane
package dbmi_pkg;

    // ****************************************************************
    // Geometry and mode register fields
    // ****************************************************************
    localparam int LANES                 = 2;
    localparam int LANE_W                = 8;
    localparam int MODE_REG_W            = 8;
    localparam int MR3_WR_INV_BIT        = 7;
    localparam int MR3_RD_INV_BIT        = 6;
    localparam int MODE_REG_THIRTEEN_MASK_BIT         = 5;
    localparam int MASK_SENSE_LO         = 2;

    // ****************************************************************
    // Thresholds, burst lengths, training storage
    // ****************************************************************
    localparam logic [3:0] RD_INV_ONES_GT = 4'h4;
    localparam logic [3:0] MASK_ONES_GE   = 4'h5;
    localparam int BEAT_CNT_W            = 6;
    localparam logic [BEAT_CNT_W-1:0] BURST_LEN_SHORT  = 6'h10;
    localparam logic [BEAT_CNT_W-1:0] BURST_LEN_LONG   = 6'h20;
    localparam logic [BEAT_CNT_W-1:0] MASKED_BURST_LEN = 6'h10;
    localparam int WR_FIFO_DEPTH         = 16;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        CMD_WRITE,
        CMD_MASKED_WRITE,
        CMD_READ,
        CMD_MODE_REG_READ,
        CMD_WRITE_FIFO_TRAINING,
        CMD_READ_FIFO_TRAINING,
        CMD_READ_DQ_CAL
    } dbmi_cmd_t;

    typedef enum logic {
        ST_IDLE,
        ST_BURST
    } dbmi_state_t;

    typedef struct packed {
        logic                        wr_inv;
        logic                        rd_inv;
        logic                        mask;
        logic                        burst_long;
    } dbmi_cfg_t;

    typedef struct packed {
        logic [LANES-1:0][LANE_W-1:0] dq;
        logic [LANES-1:0]             pin;
        logic [LANES-1:0][LANE_W-1:0] rd_data;
        logic [LANES-1:0]             cal;
    } dbmi_beat_t;

    typedef struct packed {
        logic                        valid;
        logic [LANES-1:0]            byte_en;
        logic [LANES-1:0][LANE_W-1:0] data;
    } dbmi_wr_t;

    typedef struct packed {
        logic [LANES-1:0][LANE_W-1:0] dq;
        logic [LANES-1:0]             dq_oe;
        logic [LANES-1:0]             pin;
        logic [LANES-1:0]             pin_oe;
    } dbmi_rd_t;

endpackage

// ==== verif/dbmi_lane_codec_sva.sv ====
/* Checker for the lane codec, watching top-level ports only.
   Assumes mode bits stay static while a burst runs. */
`timescale 1ns/1ps
module dbmi_lane_codec_sva
    import dbmi_pkg::*;
(
    // Core side
    input wire logic                  core_clk_in,
    input wire logic                  rst_b_in,
    input wire logic [MODE_REG_W-1:0] mode_reg_three_in,
    input wire logic [MODE_REG_W-1:0] mode_reg_thirteen_in,
    input wire logic                  burst_long_in,
    input wire logic                  illegal_mw_out,
    // Link side
    input wire logic                  link_clk_in,
    input wire logic                  cmd_valid_in,
    input wire dbmi_cmd_t             cmd_in,
    input wire logic                  beat_valid_in,
    input wire dbmi_beat_t            beat_in,
    input wire dbmi_wr_t              wr_out,
    input wire dbmi_rd_t              rd_out,
    input wire logic                  burst_busy_out
);
    // ****************************************************************
    // Burst tracking and assertions
    // ****************************************************************
    dbmi_cmd_t   cur_reg;
    logic        long_reg;
    logic [5:0]  cnt_reg;
    wire logic   take = beat_valid_in && burst_busy_out;
    wire logic   wi   = mode_reg_three_in[MR3_WR_INV_BIT];
    wire logic   ri   = mode_reg_three_in[MR3_RD_INV_BIT];
    wire logic   mk   = mode_reg_thirteen_in[MODE_REG_THIRTEEN_MASK_BIT];
    wire logic   en   = wi || mk || ri;
    wire logic [15:0] dq_inv = beat_in.dq ^ {{8{beat_in.pin[1]}}, {8{beat_in.pin[0]}}};
    wire logic [1:0]  heavy = {$countones(beat_in.rd_data[1]) > RD_INV_ONES_GT,
                               $countones(beat_in.rd_data[0]) > RD_INV_ONES_GT};
    wire logic [1:0]  drop = {!beat_in.pin[1] && $countones(beat_in.dq[1][7:2]) >= MASK_ONES_GE,
                              !beat_in.pin[0] && $countones(beat_in.dq[0][7:2]) >= MASK_ONES_GE};
    always_ff @(posedge link_clk_in) begin
        if (cmd_valid_in && !burst_busy_out) begin
            cur_reg  <= cmd_in;
            long_reg <= burst_long_in;
            cnt_reg  <= 6'h00;
        end else if (take) begin
            cnt_reg <= cnt_reg + 6'h01;
        end
    end
    default clocking cb @(posedge link_clk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_take(dbmi_cmd_t c);
        take && cur_reg == c;
    endsequence
    AST_WR_ONLY: assert property (
        s_take(CMD_READ) or s_take(CMD_READ_DQ_CAL) |=> !wr_out.valid)
        else $error("array write on a read beat");
    AST_RD_INV: assert property (
        s_take(CMD_READ) ##0 ri |=> rd_out.pin == $past(heavy) && rd_out.dq ==
        ($past(beat_in.rd_data) ^ {{8{rd_out.pin[1]}}, {8{rd_out.pin[0]}}}))
        else $error("read inversion wrong");
    AST_RD_OFF: assert property (
        (s_take(CMD_READ) or s_take(CMD_MODE_REG_READ)) ##0 !ri |=> rd_out.pin_oe == 2'b00)
        else $error("pin driven with read inversion off");
    AST_MRR: assert property (
        s_take(CMD_MODE_REG_READ) ##0 ri |=> rd_out.pin == 2'b00 && rd_out.pin_oe == 2'b11)
        else $error("mode register read pin not low");
    AST_WR_INV: assert property (
        s_take(CMD_WRITE) ##0 wi |=> wr_out.byte_en == 2'b11 && wr_out.data == $past(dq_inv))
        else $error("write inversion wrong");
    AST_RX_OFF: assert property (
        s_take(CMD_WRITE) ##0 !wi |=> wr_out.byte_en == 2'b11 && wr_out.data == $past(beat_in.dq))
        else $error("write data altered without inversion");
    AST_MASK_ONLY: assert property (
        s_take(CMD_MASKED_WRITE) ##0 (mk && !wi) |=> wr_out.byte_en == ~$past(beat_in.pin))
        else $error("mask by pin wrong");
    AST_MASK_DBI: assert property (
        s_take(CMD_MASKED_WRITE) ##0 (mk && wi) |=> wr_out.byte_en == ~$past(drop))
        else $error("mask by ones count wrong");
    AST_ILLEGAL: assert property (
        s_take(CMD_MASKED_WRITE) ##0 !mk |=> !wr_out.valid)
        else $error("illegal masked write reached the array");
    AST_FIFO_WR: assert property (
        s_take(CMD_WRITE_FIFO_TRAINING) ##0 en |=> wr_out.byte_en == 2'b11 &&
        wr_out.data == $past(beat_in.dq))
        else $error("training write data altered");
    AST_CAL: assert property (
        s_take(CMD_READ_DQ_CAL) ##0 en |=> rd_out.pin == $past(beat_in.cal))
        else $error("calibration pattern wrong");
    AST_LEN: assert property (
        $fell(burst_busy_out) |-> cnt_reg == ((cur_reg == CMD_MASKED_WRITE || !long_reg) ?
        MASKED_BURST_LEN : BURST_LEN_LONG))
        else $error("burst length wrong");
    AST_IDLE: assert property (
        !take |=> !wr_out.valid && rd_out.pin_oe == 2'b00)
        else $error("output without a beat");
    AST_PULSE: assert property (
        @(posedge core_clk_in) disable iff (!rst_b_in) illegal_mw_out |=> !illegal_mw_out)
        else $error("illegal flag longer than one cycle");
endmodule
bind dbmi_lane_codec dbmi_lane_codec_sva dbmi_lane_codec_sva_inst (.core_clk_in, .rst_b_in,
    .mode_reg_three_in, .mode_reg_thirteen_in, .burst_long_in, .illegal_mw_out, .link_clk_in,
    .cmd_valid_in, .cmd_in, .beat_valid_in, .beat_in, .wr_out, .rd_out, .burst_busy_out);

// ==== verif/dbmi_ctrl_model.sv ====
/* Memory controller model: commands and beats on the link clock.
   Assumes burst is called only while the codec is idle. */
`timescale 1ns/1ps
module dbmi_ctrl_model
    import dbmi_pkg::*;
(
    // Link side
    input  wire logic  link_clk_in,
    output logic       cmd_valid_out,
    output dbmi_cmd_t  cmd_out,
    output logic       beat_valid_out,
    output dbmi_beat_t beat_out
);
    // ****************************************************************
    // Burst driver
    // ****************************************************************
    int          seed = 32'h593a;
    logic [63:0] r;
    initial begin
        cmd_valid_out  = 1'b0;
        cmd_out        = CMD_WRITE;
        beat_valid_out = 1'b0;
        beat_out       = '0;
    end
    task automatic burst(input dbmi_cmd_t c, input int n, input logic pin_low);
        int i;
        i = 0;
        @(posedge link_clk_in) #2;
        cmd_valid_out = 1'b1;
        cmd_out = c;
        @(posedge link_clk_in) #2;
        cmd_valid_out = 1'b0;
        while (i < n) begin
            r = {$random(seed), $random(seed)};
            beat_valid_out = (r[63:62] != 2'b00) || (i == 0); // Random gaps
            beat_out = r[35:0];
            // Corner beat: ones counts of four and five on both checks
            if (i == 0) beat_out.dq = {8'hf0, 8'hf8};
            if (i == 0) beat_out.rd_data = {8'h1f, 8'h0f};
            if (i == 0) beat_out.pin = 2'b00;
            if (pin_low) beat_out.pin = 2'b00;
            if (beat_valid_out) i++;
            @(posedge link_clk_in) #2;
        end
        beat_valid_out = 1'b0;
        beat_out = ~beat_out; // Released lines never keep the last value
    endtask
endmodule

// ==== verif/dbmi_lane_codec_tb.sv ====
/* Self-checking bench for the lane codec, all eight mode combinations.
   Assumes the controller model drives the link side. */
`timescale 1ns/1ps
module dbmi_lane_codec_tb;
    import dbmi_pkg::*;
    // ****************************************************************
    // Signals, clocks, design and model
    // ****************************************************************
    logic       core_clk_in = 1'b0;
    logic       link_clk_in = 1'b0;
    logic       rst_b_in = 1'b0;
    logic [7:0] mode_reg_three_in = 8'h00;
    logic [7:0] mode_reg_thirteen_in = 8'h00;
    logic       burst_long_in = 1'b0;
    logic       illegal_mw_out, cmd_valid_in, beat_valid_in, burst_busy_out;
    dbmi_cmd_t  cmd_in, cur;
    dbmi_beat_t beat_in;
    dbmi_wr_t   wr_out, e1w = '0;
    dbmi_rd_t   rd_out, e1r = '0;
    logic [1:0] fifo [16] = '{default: 2'b00};
    logic [31:0] m;
    int         ptr, n_ill = 0, n_mismatch = 0, tests_run = 0, cyc = 0;
    wire logic  wi = mode_reg_three_in[7];
    wire logic  ri = mode_reg_three_in[6];
    wire logic  mk = mode_reg_thirteen_in[5];
    always #25 core_clk_in = ~core_clk_in;
    always #62.5 link_clk_in = ~link_clk_in;
    dbmi_lane_codec #(.FIFO_DEPTH(16)) dbmi_lane_codec_inst (.core_clk_in, .rst_b_in,
        .mode_reg_three_in, .mode_reg_thirteen_in, .burst_long_in, .illegal_mw_out, .link_clk_in,
        .cmd_valid_in, .cmd_in, .beat_valid_in, .beat_in, .wr_out, .rd_out, .burst_busy_out);
    dbmi_ctrl_model dbmi_ctrl_model_inst (.link_clk_in, .cmd_valid_out(cmd_valid_in),
        .cmd_out(cmd_in), .beat_valid_out(beat_valid_in), .beat_out(beat_in));
    // ****************************************************************
    // Expectations
    // ****************************************************************
    function automatic dbmi_wr_t f_wr(dbmi_cmd_t c, dbmi_beat_t b);
        dbmi_wr_t w;
        logic [1:0] p;
        w = '0;
        p = (wi || mk) ? b.pin : 2'b00;
        if (c == CMD_WRITE || c == CMD_WRITE_FIFO_TRAINING || (c == CMD_MASKED_WRITE && mk)) begin
            w.valid = 1'b1;
            for (int l = 0; l < 2; l++) begin
                w.data[l] = (wi && c != CMD_WRITE_FIFO_TRAINING && p[l]) ? ~b.dq[l] : b.dq[l];
                w.byte_en[l] = (c != CMD_MASKED_WRITE) ? 1'b1 :
                    wi ? !(!p[l] && $countones(b.dq[l][7:2]) >= 5) : !p[l];
            end
        end
        return w;
    endfunction
    function automatic dbmi_rd_t f_rd(dbmi_cmd_t c, dbmi_beat_t b, logic [1:0] fp);
        dbmi_rd_t r;
        r = '0;
        if (c >= CMD_READ && c != CMD_WRITE_FIFO_TRAINING) begin
            r.dq_oe = 2'b11;
            r.dq = b.rd_data;
            for (int l = 0; l < 2; l++) begin
                if (c == CMD_READ && ri && $countones(b.rd_data[l]) > 4) begin
                    r.dq[l] = ~b.rd_data[l];
                    r.pin[l] = 1'b1;
                end
            end
            r.pin_oe = (c <= CMD_MODE_REG_READ) ? {2{ri}} : {2{wi || mk || ri}};
            if (c == CMD_READ_FIFO_TRAINING) r.pin = fp;
            if (c == CMD_READ_DQ_CAL) r.pin = b.cal;
        end
        return r;
    endfunction
    always @(posedge link_clk_in) begin
        e1w <= '0;
        e1r <= '0;
        if (cmd_valid_in) begin
            cur <= cmd_in;
            ptr <= 0;
        end else if (beat_valid_in) begin
            e1w <= f_wr(cur, beat_in);
            e1r <= f_rd(cur, beat_in, fifo[ptr % 16]);
            if (cur == CMD_WRITE_FIFO_TRAINING)
                fifo[ptr % 16] <= (wi || mk || ri) ? beat_in.pin : 2'b00;
            ptr <= ptr + 1;
        end
    end
    // ****************************************************************
    // Comparison, timeout and verdict
    // ****************************************************************
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(negedge link_clk_in) begin
        if (rst_b_in) begin
            m = {{8{e1w.byte_en[1]}}, {8{e1w.byte_en[0]}}, {8{e1r.dq_oe[1]}}, {8{e1r.dq_oe[0]}}};
            check({wr_out.valid, wr_out.byte_en, wr_out.data & m[31:16]},
                  {e1w.valid, e1w.byte_en, e1w.data & m[31:16]});
            check({rd_out.dq & m[15:0], rd_out.dq_oe, rd_out.pin & e1r.pin_oe, rd_out.pin_oe},
                  {e1r.dq, e1r.dq_oe, e1r.pin & e1r.pin_oe, e1r.pin_oe});
        end
    end
    always @(posedge core_clk_in) begin
        cyc++;
        if (illegal_mw_out === 1'b1) n_ill++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    // Masked writes stay at sixteen beats even in long-burst mode
    task automatic run(input dbmi_cmd_t c);
        int n0;
        n0 = n_ill;
        dbmi_ctrl_model_inst.burst(c, (c == CMD_MASKED_WRITE || !burst_long_in) ? 16 : 32,
            c == CMD_WRITE && mk && !wi);
        repeat (8) @(posedge core_clk_in);
        check(burst_busy_out, 1'b0);
        check(n_ill, n0 + (c == CMD_MASKED_WRITE && !mk));
    endtask
    initial begin
        // Reset outlasts three link edges, longer than three core cycles
        repeat (8) @(posedge core_clk_in);
        #2 rst_b_in = 1'b1;
        for (int k = 0; k < 9; k++) begin
            @(posedge core_clk_in) #2;
            mode_reg_three_in = {k[0] | k[3], k[1] | k[3], 6'h3f};
            mode_reg_thirteen_in = {2'b11, k[2] | k[3], 5'h1f};
            burst_long_in = (k == 8);
            repeat (8) @(posedge link_clk_in);
            for (int c = 4; c < 11; c++) run(dbmi_cmd_t'(c % 7));
        end
        summarize();
    end
endmodule
